// ### core/ssi_top.sv
// Operation
// - per task, flag source/target line event when selected counter reaches threshold
// - zero threshold raises the line event on every line
// - bit 28 target select, bit 12 source select: 0 horizontal, 1 binary-ratio
// - target threshold bits 27..16, source threshold bits 11..0, rest reserved
// - timeout settings govern pause/deadline-check waits; zero count disables timeout
// - bit 31 vsync mode, bit 30 clock mode: none, clock, vsync, both
// - bit 29 picks vsync port for timeout: 1 port A, 0 port B
// - bits 27..24 give vsync timeout of 1 to 15 syncs
// - bits 23..0 give bus clock cycles before timeout is detected
// - interrupt status set from primary status events or status writes, with enable set
// - writing 1 clears an interrupt status bit, otherwise it stays
// - status writes change no status; writing 1 triggers enabled interrupt
// - some primary bits summarise groups of secondary status bits
// - bit 31 bus parity error, interrupt on rising edge
// - bit 30 device-started access aborted, interrupt on rising edge
// - bit 29 real-time parity error since last port A vsync or last wait
// - bits 28/27 sequencer command interrupt from task 1/task 0
// - bits 26/25 set by deadline check, cleared on task restart
// - bits 24/23 reflect task secondary error bits, cleared on restart
// - bit 22 set when task 1 waits past timeout, cleared on restart
// - bit 21 set when task 0 waits past timeout, cleared on restart
`include "ssi_consts.svh"
`default_nettype none
module ssi_top import ssi_pkg::*; (
  input wire logic I_CORE_CLK,
  input wire logic I_RSTN,
  input wire logic [8:0] I_ADDR,
  input wire logic [31:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  input wire logic [11:0] I_HSC_SRC_LINE,
  input wire logic [11:0] I_HSC_TGT_LINE,
  input wire logic [11:0] I_BRS_SRC_LINE,
  input wire logic [11:0] I_BRS_TGT_LINE,
  input wire logic [1:0] I_TASK_START,
  input wire logic [1:0] I_TASK_WAIT,
  input wire logic [1:0] I_SEQ_IRQ,
  input wire logic [1:0] I_DEADLINE_MISSED,
  input wire logic [3:0] I_SEQ_ERR_T0,
  input wire logic [3:0] I_SEQ_ERR_T1,
  input wire logic I_BUS_PARITY_ERR,
  input wire logic I_BUS_ABORT_ERR,
  input wire logic I_RT_PARITY_ERR,
  input wire logic I_VSYNC_A,
  input wire logic I_VSYNC_B,
  output logic [31:0] O_RDATA,
  output logic [1:0] O_SRC_LINE_EVT,
  output logic [1:0] O_TGT_LINE_EVT,
  output logic [1:0] O_WAIT_TIMEOUT
);

  ssi_state_t q;
  ssi_state_t d;

  // a counter that moved onto the threshold, or any move when threshold is zero
  function automatic logic line_hit(input logic [11:0] cnt, input logic [11:0] prev,
                                    input logic [11:0] thr);
    line_hit = (cnt != prev) && ((thr == 12'h000) || (cnt == thr));
  endfunction

  function automatic logic [31:0] reg_read(input ssi_state_t s, input logic [8:0] a);
    unique case (a)
      `SSI_OFS_THR0: reg_read = s.thr[0];
      `SSI_OFS_THR1: reg_read = s.thr[1];
      `SSI_OFS_TOC0: reg_read = s.toc[0];
      `SSI_OFS_TOC1: reg_read = s.toc[1];
      `SSI_OFS_IEN: reg_read = s.ien;
      `SSI_OFS_IST: reg_read = s.ist;
      `SSI_OFS_PST: reg_read = s.pst;
      default: reg_read = 32'h0000_0000;
    endcase
  endfunction

  logic [1:0] hsc_src_hit;
  logic [1:0] hsc_tgt_hit;
  logic [1:0] brs_src_hit;
  logic [1:0] brs_tgt_hit;
  logic [1:0] vs_edge;
  logic [1:0] wait_entry;
  logic [1:0] task_vs;
  logic [1:0] clk_expire;
  logic [1:0] vs_expire;
  logic [1:0] err_any;
  logic [31:0] pst_n;
  logic [31:0] ist_set;
  logic [31:0] ist_clr;
  logic [11:0] src_thr;
  logic [11:0] tgt_thr;
  logic [3:0] vcfg;
  logic [23:0] ccfg;

  always_comb begin
    d = q;
    hsc_src_hit = '0;
    hsc_tgt_hit = '0;
    brs_src_hit = '0;
    brs_tgt_hit = '0;
    task_vs = '0;
    clk_expire = '0;
    vs_expire = '0;
    src_thr = 12'h000;
    tgt_thr = 12'h000;
    vcfg = 4'h0;
    ccfg = 24'h00_0000;

    // vsync pins: two-stage synchroniser, edges seen only after the second stage
    d.vs_meta = {I_VSYNC_A, I_VSYNC_B};
    d.vs_sync = q.vs_meta;
    d.vs_prev = q.vs_sync;
    vs_edge = q.vs_sync & ~q.vs_prev;

    d.wait_prev = I_TASK_WAIT;
    wait_entry = I_TASK_WAIT & ~q.wait_prev;

    d.hsc_src_prev = I_HSC_SRC_LINE;
    d.hsc_tgt_prev = I_HSC_TGT_LINE;
    d.brs_src_prev = I_BRS_SRC_LINE;
    d.brs_tgt_prev = I_BRS_TGT_LINE;

    for (int t = 0; t < 2; t++) begin
      src_thr = q.thr[t][`SSI_THR_STHR_HI:`SSI_THR_STHR_LO];
      tgt_thr = q.thr[t][`SSI_THR_TTHR_HI:`SSI_THR_TTHR_LO];
      hsc_src_hit[t] = line_hit(I_HSC_SRC_LINE, q.hsc_src_prev, src_thr);
      brs_src_hit[t] = line_hit(I_BRS_SRC_LINE, q.brs_src_prev, src_thr);
      hsc_tgt_hit[t] = line_hit(I_HSC_TGT_LINE, q.hsc_tgt_prev, tgt_thr);
      brs_tgt_hit[t] = line_hit(I_BRS_TGT_LINE, q.brs_tgt_prev, tgt_thr);
      // one-cycle pulses; a threshold written late simply misses the line already passed
      d.src_evt[t] = q.thr[t][`SSI_THR_SSEL] ? brs_src_hit[t] : hsc_src_hit[t];
      d.tgt_evt[t] = q.thr[t][`SSI_THR_TSEL] ? brs_tgt_hit[t] : hsc_tgt_hit[t];

      vcfg = q.toc[t][`SSI_TOC_VCNT_HI:`SSI_TOC_VCNT_LO];
      ccfg = q.toc[t][`SSI_TOC_CCNT_HI:`SSI_TOC_CCNT_LO];
      task_vs[t] = q.toc[t][`SSI_TOC_PORTA] ? vs_edge[1] : vs_edge[0];

      if (wait_entry[t] || I_TASK_START[t]) begin
        d.ccnt[t] = ccfg;
        d.vcnt[t] = vcfg;
      end else if (I_TASK_WAIT[t]) begin
        // counters rest at zero after expiry, so each wait times out once
        if (q.toc[t][`SSI_TOC_CMODE] && (ccfg != 24'h00_0000) &&
            (q.ccnt[t] != 24'h00_0000)) begin
          d.ccnt[t] = q.ccnt[t] - 24'h00_0001;
          clk_expire[t] = (q.ccnt[t] == 24'h00_0001);
        end
        if (q.toc[t][`SSI_TOC_VMODE] && (vcfg != 4'h0) &&
            (q.vcnt[t] != 4'h0) && task_vs[t]) begin
          d.vcnt[t] = q.vcnt[t] - 4'h1;
          vs_expire[t] = (q.vcnt[t] == 4'h1);
        end
      end
    end

    // primary status: hardware sets, restart or vsync clears, sets win
    err_any = {|I_SEQ_ERR_T1, |I_SEQ_ERR_T0};
    pst_n = q.pst;
    if (I_TASK_START[1]) begin
      pst_n[`SSI_PS_LATE_T1] = 1'b0;
      pst_n[`SSI_PS_ERR_T1] = 1'b0;
      pst_n[`SSI_PS_TO_T1] = 1'b0;
      pst_n[`SSI_PS_IRQ_T1] = 1'b0;
    end
    if (I_TASK_START[0]) begin
      pst_n[`SSI_PS_LATE_T0] = 1'b0;
      pst_n[`SSI_PS_ERR_T0] = 1'b0;
      pst_n[`SSI_PS_TO_T0] = 1'b0;
      pst_n[`SSI_PS_IRQ_T0] = 1'b0;
    end
    // real-time parity window restarts at each port A vsync or any wait entry
    if (vs_edge[1] || (|wait_entry)) begin
      pst_n[`SSI_PS_RT_PAR] = 1'b0;
    end
    // bus error flags are sticky until their interrupt bit is acknowledged
    if (I_WR && (I_ADDR == `SSI_OFS_IST)) begin
      if (I_WDATA[`SSI_PS_BUS_PAR]) begin
        pst_n[`SSI_PS_BUS_PAR] = 1'b0;
      end
      if (I_WDATA[`SSI_PS_BUS_ABORT]) begin
        pst_n[`SSI_PS_BUS_ABORT] = 1'b0;
      end
    end
    if (I_BUS_PARITY_ERR) begin
      pst_n[`SSI_PS_BUS_PAR] = 1'b1;
    end
    if (I_BUS_ABORT_ERR) begin
      pst_n[`SSI_PS_BUS_ABORT] = 1'b1;
    end
    if (I_RT_PARITY_ERR) begin
      pst_n[`SSI_PS_RT_PAR] = 1'b1;
    end
    if (I_SEQ_IRQ[1]) begin
      pst_n[`SSI_PS_IRQ_T1] = 1'b1;
    end
    if (I_SEQ_IRQ[0]) begin
      pst_n[`SSI_PS_IRQ_T0] = 1'b1;
    end
    if (I_DEADLINE_MISSED[1]) begin
      pst_n[`SSI_PS_LATE_T1] = 1'b1;
    end
    if (I_DEADLINE_MISSED[0]) begin
      pst_n[`SSI_PS_LATE_T0] = 1'b1;
    end
    if (err_any[1]) begin
      pst_n[`SSI_PS_ERR_T1] = 1'b1;
    end
    if (err_any[0]) begin
      pst_n[`SSI_PS_ERR_T0] = 1'b1;
    end
    if (clk_expire[1] || vs_expire[1]) begin
      pst_n[`SSI_PS_TO_T1] = 1'b1;
    end
    if (clk_expire[0] || vs_expire[0]) begin
      pst_n[`SSI_PS_TO_T0] = 1'b1;
    end
    d.pst = pst_n & `SSI_IRQ_MASK;

    // interrupt status: rising edges of status plus software triggers, gated by enable
    ist_set = pst_n & ~q.pst;
    if (I_WR && (I_ADDR == `SSI_OFS_PST)) begin
      ist_set = ist_set | I_WDATA;
    end
    ist_set = ist_set & q.ien & `SSI_IRQ_MASK;
    ist_clr = '0;
    if (I_WR && (I_ADDR == `SSI_OFS_IST)) begin
      ist_clr = I_WDATA;
    end
    d.ist = (q.ist & ~ist_clr) | ist_set;

    // register writes; status stays read-only
    if (I_WR) begin
      unique case (I_ADDR)
        `SSI_OFS_THR0: d.thr[0] = I_WDATA & `SSI_THR_MASK;
        `SSI_OFS_THR1: d.thr[1] = I_WDATA & `SSI_THR_MASK;
        `SSI_OFS_TOC0: d.toc[0] = I_WDATA & `SSI_TOC_MASK;
        `SSI_OFS_TOC1: d.toc[1] = I_WDATA & `SSI_TOC_MASK;
        `SSI_OFS_IEN: d.ien = I_WDATA & `SSI_IRQ_MASK;
        default: d.rdata = q.rdata;
      endcase
    end

    // read data only in the cycle after the strobe
    if (I_RD) begin
      d.rdata = reg_read(q, I_ADDR);
    end else begin
      d.rdata = `SSI_RST_RDATA;
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign O_RDATA = q.rdata;
  assign O_SRC_LINE_EVT = q.src_evt;
  assign O_TGT_LINE_EVT = q.tgt_evt;
  assign O_WAIT_TIMEOUT = {q.pst[`SSI_PS_TO_T1], q.pst[`SSI_PS_TO_T0]};

endmodule
`default_nettype wire

// ### core/ssi_consts.svh
`ifndef SSI_CONSTS_SVH
`define SSI_CONSTS_SVH

// register byte offsets
`define SSI_OFS_THR0 9'h0CC
`define SSI_OFS_THR1 9'h0D0
`define SSI_OFS_TOC0 9'h0D4
`define SSI_OFS_TOC1 9'h0D8
`define SSI_OFS_IEN 9'h0E0
`define SSI_OFS_IST 9'h0E4
`define SSI_OFS_PST 9'h110

// writable bits of each register, reserved bits read zero
`define SSI_THR_MASK 32'h1FFF_1FFF
`define SSI_TOC_MASK 32'hEFFF_FFFF
`define SSI_IRQ_MASK 32'hFFE0_0000

// line threshold fields
`define SSI_THR_TSEL 28
`define SSI_THR_TTHR_HI 27
`define SSI_THR_TTHR_LO 16
`define SSI_THR_SSEL 12
`define SSI_THR_STHR_HI 11
`define SSI_THR_STHR_LO 0

// timeout configuration fields
`define SSI_TOC_VMODE 31
`define SSI_TOC_CMODE 30
`define SSI_TOC_PORTA 29
`define SSI_TOC_VCNT_HI 27
`define SSI_TOC_VCNT_LO 24
`define SSI_TOC_CCNT_HI 23
`define SSI_TOC_CCNT_LO 0

// primary status bit positions
`define SSI_PS_BUS_PAR 31
`define SSI_PS_BUS_ABORT 30
`define SSI_PS_RT_PAR 29
`define SSI_PS_IRQ_T1 28
`define SSI_PS_IRQ_T0 27
`define SSI_PS_LATE_T1 26
`define SSI_PS_LATE_T0 25
`define SSI_PS_ERR_T1 24
`define SSI_PS_ERR_T0 23
`define SSI_PS_TO_T1 22
`define SSI_PS_TO_T0 21

// reset values
`define SSI_RST_REG 32'h0000_0000
`define SSI_RST_RDATA 32'h0000_0000

`endif

// ### core/ssi_pkg.sv
`default_nettype none
package ssi_pkg;
  typedef struct packed {
    logic [1:0][31:0] thr;
    logic [1:0][31:0] toc;
    logic [31:0] ien;
    logic [31:0] ist;
    logic [31:0] pst;
    logic [1:0][23:0] ccnt;
    logic [1:0][3:0] vcnt;
    logic [1:0] wait_prev;
    logic [1:0] vs_meta;
    logic [1:0] vs_sync;
    logic [1:0] vs_prev;
    logic [11:0] hsc_src_prev;
    logic [11:0] hsc_tgt_prev;
    logic [11:0] brs_src_prev;
    logic [11:0] brs_tgt_prev;
    logic [1:0] src_evt;
    logic [1:0] tgt_evt;
    logic [31:0] rdata;
  } ssi_state_t;
endpackage
`default_nettype wire

// ### testbench/ssi_top_asserts.sv
`include "ssi_consts.svh"
`default_nettype none
module ssi_top_asserts (
  input wire logic I_CORE_CLK,
  input wire logic I_RSTN,
  input wire logic [8:0] I_ADDR,
  input wire logic [31:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  input wire logic [11:0] I_HSC_SRC_LINE,
  input wire logic [11:0] I_BRS_SRC_LINE,
  input wire logic [1:0] I_TASK_START,
  input wire logic [1:0] I_TASK_WAIT,
  input wire logic [31:0] O_RDATA,
  input wire logic [1:0] O_SRC_LINE_EVT,
  input wire logic [1:0] O_WAIT_TIMEOUT
);
  default clocking @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RSTN);
  chk_rd_idle: assert property (
    !$past(I_RD) |-> O_RDATA == 32'h0) else $error("read data outside read slot");
  chk_thr_readback: assert property (
    I_WR && I_ADDR == `SSI_OFS_THR0 ##2 I_RD && I_ADDR == `SSI_OFS_THR0
    |=> O_RDATA == ($past(I_WDATA, 3) & `SSI_THR_MASK)) else $error("threshold readback");
  chk_toc_readback: assert property (
    I_WR && I_ADDR == `SSI_OFS_TOC0 ##2 I_RD && I_ADDR == `SSI_OFS_TOC0
    |=> O_RDATA == ($past(I_WDATA, 3) & `SSI_TOC_MASK)) else $error("timeout cfg readback");
  chk_evt_cause: assert property (
    O_SRC_LINE_EVT[0] |-> $past(I_HSC_SRC_LINE) != $past(I_HSC_SRC_LINE, 2) ||
    $past(I_BRS_SRC_LINE) != $past(I_BRS_SRC_LINE, 2)) else $error("line event without change");
  chk_to0_clear: assert property (
    I_TASK_START[0] |=> !O_WAIT_TIMEOUT[0]) else $error("task 0 timeout not cleared");
  chk_to1_clear: assert property (
    I_TASK_START[1] |=> !O_WAIT_TIMEOUT[1]) else $error("task 1 timeout not cleared");
  chk_to0_hold: assert property (
    O_WAIT_TIMEOUT[0] && !I_TASK_START[0] |=> O_WAIT_TIMEOUT[0]) else $error("timeout dropped");
  chk_to_needs_wait: assert property (
    $rose(O_WAIT_TIMEOUT[0]) |-> $past(I_TASK_WAIT[0])) else $error("timeout outside wait");
  cover property (O_SRC_LINE_EVT[0]);
  cover property ($rose(O_WAIT_TIMEOUT[0]));
  cover property ($rose(O_WAIT_TIMEOUT[1]));
endmodule
`default_nettype wire

// ### testbench/ssi_host.sv
`default_nettype none
module ssi_host (
  input wire logic clk,
  output logic [8:0] addr,
  output logic [31:0] wdata,
  output logic wr,
  output logic rd
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] q[$];
  initial begin
    addr = 9'h0;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
  end
  // idle cycle after each access so no strobe is assigned twice in one step
  task automatic acc(input logic w, input logic [8:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    if (!w) q.push_back(d);
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ### testbench/ssi_top_tb.sv
`include "ssi_consts.svh"
`default_nettype none
module ssi_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rstn = 0, rp = 0, wr, rd, bp = 0, va = 0, vb = 0, ab = 0, rtp = 0;
  logic [8:0] addr;
  logic [31:0] wdata, rdata, d;
  logic [11:0] hs = 0, bs = 0;
  logic [1:0] st = 0, wt = 0, irq = 0, dl = 0, sevt, tevt, wto;
  logic [3:0] er0 = 0, er1 = 0;
  int fails = 0, num_checks = 0, n, s0, t0, s1, t1;
  always #5 clk = ~clk;
  ssi_host h(.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd));
  ssi_top DUT(.I_CORE_CLK(clk), .I_RSTN(rstn), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr),
    .I_RD(rd), .I_HSC_SRC_LINE(hs), .I_HSC_TGT_LINE(hs), .I_BRS_SRC_LINE(bs),
    .I_BRS_TGT_LINE(bs), .I_TASK_START(st), .I_TASK_WAIT(wt), .I_SEQ_IRQ(irq),
    .I_DEADLINE_MISSED(dl), .I_SEQ_ERR_T0(er0), .I_SEQ_ERR_T1(er1), .I_BUS_PARITY_ERR(bp),
    .I_BUS_ABORT_ERR(ab), .I_RT_PARITY_ERR(rtp), .I_VSYNC_A(va), .I_VSYNC_B(vb),
    .O_RDATA(rdata), .O_SRC_LINE_EVT(sevt), .O_TGT_LINE_EVT(tevt), .O_WAIT_TIMEOUT(wto));
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    num_checks++;
    if (g !== x) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  task automatic results();
    $display("checks=%0d fails=%0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge clk) begin
    if (rp) chk(rdata, h.q.pop_front());
    rp <= rd;
  end
  // counters sweep 0..7, binary-ratio side runs 8 above the horizontal one
  task automatic ramp();
    s0 = 0;
    t0 = 0;
    s1 = 0;
    t1 = 0;
    for (int i = 0; i < 12; i++) begin
      @(posedge clk);
      s0 += sevt[0];
      t0 += tevt[0];
      s1 += sevt[1];
      t1 += tevt[1];
      hs <= 12'(i < 8 ? i : 7);
      bs <= 12'(i < 8 ? i + 8 : 15);
    end
  endtask
  task automatic vpulse(input int k, input logic a);
    repeat (k) begin
      @(posedge clk);
      if (a) va <= 1;
      else vb <= 1;
      repeat (4) @(posedge clk);
      va <= 0;
      vb <= 0;
      repeat (4) @(posedge clk);
    end
  endtask
  initial begin
    #50us;
    fails++;
    results();
  end
  initial begin
    logic [8:0] ra[5] = '{9'h0CC, 9'h0D0, 9'h0D4, 9'h0D8, 9'h0E0};
    logic [31:0] rm[5] = '{`SSI_THR_MASK, `SSI_THR_MASK, `SSI_TOC_MASK, `SSI_TOC_MASK,
      `SSI_IRQ_MASK};
    logic [31:0] cfg[2] = '{32'h0000_0005, 32'h4000_0000};
    void'($urandom(97));
    repeat (20) @(posedge clk);
    rstn <= 1;
    @(posedge clk);
    foreach (ra[k]) begin
      d = $urandom;
      h.acc(0, ra[k], 32'h0);
      h.acc(1, ra[k], d);
      h.acc(0, ra[k], d & rm[k]);
    end
    h.acc(1, 9'h1FC, d);
    h.acc(0, 9'h1FC, 32'h0);
    h.acc(1, 9'h0D0, 32'h0);
    h.acc(1, 9'h0D8, 32'h0);
    h.acc(1, 9'h0E0, 32'h1820_0000);
    h.acc(1, 9'h0CC, 32'h100B_0005);
    ramp();
    chk(s0, 1);
    chk(t0, 1);
    chk(s1, 7);
    chk(t1, 7);
    h.acc(1, 9'h0CC, 32'h0);
    ramp();
    chk(s0, 8);
    chk(t0, 8);
    chk(t1, 8);
    irq[0] <= 1;
    @(posedge clk);
    irq[0] <= 0;
    h.acc(0, 9'h110, 32'h0800_0000);
    h.acc(0, 9'h0E4, 32'h0800_0000);
    h.acc(1, 9'h110, 32'h1000_0000);
    h.acc(0, 9'h0E4, 32'h1800_0000);
    h.acc(0, 9'h110, 32'h0800_0000);
    h.acc(1, 9'h0E4, 32'h0800_0000);
    h.acc(0, 9'h0E4, 32'h1000_0000);
    h.acc(1, 9'h0E4, 32'h1000_0000);
    st <= 1;
    @(posedge clk);
    st <= 0;
    bp <= 1;
    ab <= 1;
    rtp <= 1;
    dl[1] <= 1;
    er1 <= 4'h2;
    er0 <= 4'h8;
    @(posedge clk);
    bp <= 0;
    ab <= 0;
    rtp <= 0;
    dl[1] <= 0;
    er1 <= 4'h0;
    er0 <= 4'h0;
    h.acc(0, 9'h110, 32'hE580_0000);
    st <= 2'b11;
    @(posedge clk);
    st <= 0;
    h.acc(1, 9'h0E4, 32'hC000_0000);
    h.acc(0, 9'h110, 32'h2000_0000);
    n = $urandom_range(20, 2);
    h.acc(1, 9'h0D4, 32'h4000_0000 | n);
    wt[0] <= 1;
    repeat (n - 1) @(posedge clk);
    chk(wto, 0);
    repeat (5) @(posedge clk);
    chk(wto, 1);
    h.acc(0, 9'h110, 32'h0020_0000);
    h.acc(0, 9'h0E4, 32'h0020_0000);
    wt[0] <= 0;
    h.acc(1, 9'h0E4, 32'h0020_0000);
    st <= 1;
    @(posedge clk);
    st <= 0;
    repeat (2) @(posedge clk);
    chk(wto, 0);
    foreach (cfg[k]) begin
      h.acc(1, 9'h0D4, cfg[k]);
      wt[0] <= 1;
      repeat (25) @(posedge clk);
      chk(wto, 0);
      wt[0] <= 0;
    end
    h.acc(1, 9'h0D8, 32'hE200_0000);
    wt[1] <= 1;
    vpulse(3, 0);
    chk(wto, 0);
    vpulse(2, 1);
    chk(wto, 2);
    results();
  end
endmodule
bind ssi_top ssi_top_asserts u_chk(.I_CORE_CLK(I_CORE_CLK), .I_RSTN(I_RSTN),
  .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD),
  .I_HSC_SRC_LINE(I_HSC_SRC_LINE), .I_BRS_SRC_LINE(I_BRS_SRC_LINE),
  .I_TASK_START(I_TASK_START), .I_TASK_WAIT(I_TASK_WAIT), .O_RDATA(O_RDATA),
  .O_SRC_LINE_EVT(O_SRC_LINE_EVT), .O_WAIT_TIMEOUT(O_WAIT_TIMEOUT));
`default_nettype wire
